// ===== pkg/period_timer_pwm_pkg.sv
// Shared constants for the period timer and PWM block: register map, field positions,
// reset values and timing figures.
// Assumes a single 250 MHz system clock that stands in for the oscillator clock.
//
// Functional notes
// (RULE_01) Timer runs from instruction clock, system clock over four, prescaler before count.
// (RULE_02) Timer count advances by one per prescaled edge, counting up from zero.
// (RULE_03) Prescale code 00/01/10/11 divides by 1, 4, 16, 64.
// (RULE_04) Count compared to period each cycle; match pulses and reloads zero next.
// (RULE_05) Postscaler counts matches, ratio 1:1 to 1:16, each completion sets flag.
// (RULE_06) Postscaler output latches flag; request raised only when enable bit set.
// (RULE_07) Reset clears count, period becomes all ones; both read and write.
// (RULE_08) Count write, control write and reset clear pre and postscaler; count kept.
// (RULE_09) Control bit 2 runs the timer when set, stops it when clear.
// (RULE_10) Match pulse offered to other peripherals, synchronous to system clock.
// (RULE_11) Sleep stops counting, holds count and period, resumes from held count.
// (RULE_12) Sleep keeps each driven PWM pin at its level; module state frozen.
// (RULE_13) Outputs go active at period boundary reload, except duty zero stays inactive.
// (RULE_14) Output goes inactive when 10-bit time base equals 10-bit duty.
// (RULE_15) Duty beyond the period span never clears output: full duty.
// (RULE_16) Duty registers double buffered, copied into active buffer at period reload.
// (RULE_17) Software updates both duty halves before the next match.
// (RULE_18) Polarity bit inverts the channel output level.
// (RULE_19) Period is (period+1) times four clocks times prescale, shared by channels.
// (RULE_20) Time base is count with two low bits of prescaled clocks appended.
// (RULE_21) Postscaler affects only the flag rate, never PWM timing.
// (RULE_22) Clearing pin drive enable releases the pin to the port latch.
// (RULE_23) Channel enable bit turns generation for that channel on or off.
// (RULE_24) Polarity one gives active-low output, zero gives active-high.

package period_timer_pwm_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PERIOD_VALUE = 8'h04;
	localparam logic [7:0] OFS_TIMER_COUNT = 8'h08;
	localparam logic [7:0] OFS_MATCH_IRQ = 8'h0C;
	localparam logic [7:0] OFS_CHAN_BASE = 8'h10;
	localparam logic [7:0] CHAN_STRIDE = 8'h10;
	localparam logic [7:0] OFS_CHAN_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CHAN_DUTY_HIGH = 8'h04;
	localparam logic [7:0] OFS_CHAN_DUTY_LOW = 8'h08;

	// Timer control fields
	localparam int PRESCALE_LSB = 0;
	localparam int RUN_BIT = 2;
	localparam int POSTSCALE_LSB = 3;
	localparam logic [7:0] TIMER_CONTROL_MASK = 8'h7F;

	// Match interrupt register fields
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_ENABLE_BIT = 1;

	// Channel control fields
	localparam int CH_ENABLE_BIT = 7;
	localparam int CH_DRIVE_BIT = 6;
	localparam int CH_OUT_BIT = 5;
	localparam int CH_INVERT_BIT = 4;
	localparam int DUTY_LOW_LSB = 6;

	// Reset values
	localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIOD_VALUE_RST = 8'hFF;
	localparam logic [7:0] TIMER_COUNT_RST = 8'h00;
	localparam logic [9:0] DUTY_RST = 10'h000;

	// System clocks per instruction clock
	localparam int CLOCKS_PER_INSTR = 4;
	localparam logic [7:0] INSTR_LAST = 8'(CLOCKS_PER_INSTR - 1);

endpackage

// ===== hw/period_timer_pwm.sv
// Period timer with prescaler and postscaler, shared by a set of 10-bit PWM channels.
// Registers sit behind an Avalon-MM slave with waitrequest; sleep and the port data latch
// come from logic on the same clock, so they are read without synchronisers.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module period_timer_pwm #(
	parameter int CHANNELS = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Avalon-MM slave
	input wire logic [period_timer_pwm_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [period_timer_pwm_pkg::DATA_W-1:0] writedata,
	output logic [period_timer_pwm_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// System state
	input wire logic sleep,
	// Timer outputs to other peripherals
	output logic period_match_pulse,
	output logic match_irq_request,
	// PWM levels to other peripherals
	output logic [CHANNELS-1:0] pwm_level,
	// PWM pins
	input wire logic [CHANNELS-1:0] port_latch,
	output logic [CHANNELS-1:0] pwm_pin_out,
	output logic [CHANNELS-1:0] pwm_pin_oe
);
	import period_timer_pwm_pkg::*;

	// Software visible state
	logic [1:0] prescale_select;
	logic timer_run;
	logic [3:0] postscale_select;
	logic [7:0] period_value;
	logic [7:0] timer_count;
	logic match_irq_flag;
	logic match_irq_enable;
	logic [CHANNELS-1:0] channel_enable;
	logic [CHANNELS-1:0] pin_drive_enable;
	logic [CHANNELS-1:0] output_invert;
	logic [7:0] duty_high_bits [CHANNELS];
	logic [1:0] duty_low_bits [CHANNELS];

	// Internal timing state
	logic [7:0] prescale_count;
	logic [3:0] postscale_count;
	logic [9:0] duty_active [CHANNELS];
	logic [CHANNELS-1:0] pwm_raw;

	// Bus handshake
	logic access_done;
	logic do_write;
	logic [7:0] byte_addr;
	logic wr_control;
	logic wr_period;
	logic wr_count;
	logic wr_irq;

	// Timing decode
	logic running;
	logic [7:0] prescale_last;
	logic tick;
	logic reload;
	logic [1:0] time_low;
	logic [9:0] time_base;
	logic post_done;

	// Last system clock of one timer increment: four per instruction clock times prescale
	function automatic logic [7:0] last_clock(input logic [1:0] sel);
		last_clock = 8'((32'(INSTR_LAST) + 32'd1) * (32'd1 << (2 * 32'(sel))) - 32'd1);
	endfunction

	// Two time base bits below the count, taken from the prescale counter
	function automatic logic [1:0] low_bits(input logic [7:0] cnt, input logic [1:0] sel);
		logic [7:0] shifted;
		shifted = cnt >> (2 * sel);
		low_bits = shifted[1:0];
	endfunction

	// Channel register decode, index of the channel or -1
	function automatic int chan_of(input logic [7:0] a);
		int idx;
		idx = -1;
		for (int c = 0; c < CHANNELS; c++) begin
			if (a >= OFS_CHAN_BASE + 8'(c) * CHAN_STRIDE &&
				a < OFS_CHAN_BASE + 8'(c + 1) * CHAN_STRIDE) begin
				idx = c;
			end
		end
		chan_of = idx;
	endfunction

	// Accepted write happens on the edge where waitrequest is seen low
	assign do_write = write && !waitrequest;
	assign byte_addr = 8'(address);
	assign wr_control = do_write && byte_addr == OFS_TIMER_CONTROL;
	assign wr_period = do_write && byte_addr == OFS_PERIOD_VALUE;
	assign wr_count = do_write && byte_addr == OFS_TIMER_COUNT;
	assign wr_irq = do_write && byte_addr == OFS_MATCH_IRQ;

	// Timer advances only while on and awake
	assign running = timer_run && !sleep; // [RULE_09] [RULE_11]
	assign prescale_last = last_clock(prescale_select); // [RULE_01] [RULE_03]
	assign tick = running && prescale_count == prescale_last;
	assign reload = tick && timer_count == period_value; // [RULE_04]
	assign time_low = low_bits(prescale_count, prescale_select); // [RULE_20]
	assign time_base = {timer_count, time_low}; // [RULE_20]
	assign post_done = postscale_count == postscale_select; // [RULE_05]

	// Bus answer: one wait cycle, then a single cycle with waitrequest low
	always_ff @(posedge clock) begin
		if (srst) begin
			waitrequest <= 1'b1;
			access_done <= 1'b0;
		end else if (!waitrequest) begin
			waitrequest <= 1'b1;
			access_done <= 1'b1;
		end else if ((read || write) && !access_done) begin
			waitrequest <= 1'b0;
		end else begin
			access_done <= 1'b0;
		end
	end

	// Read data captured while waitrequest is still high, so it stands at the taking edge
	always_ff @(posedge clock) begin
		if (srst) begin
			readdata <= '0;
		end else if (read && waitrequest && !access_done) begin
			if (byte_addr == OFS_TIMER_CONTROL) begin
				readdata <= DATA_W'({1'b0, postscale_select, timer_run, prescale_select});
			end else if (byte_addr == OFS_PERIOD_VALUE) begin
				readdata <= DATA_W'(period_value); // [RULE_07]
			end else if (byte_addr == OFS_TIMER_COUNT) begin
				readdata <= DATA_W'(timer_count); // [RULE_07]
			end else if (byte_addr == OFS_MATCH_IRQ) begin
				readdata <= DATA_W'({match_irq_enable, match_irq_flag});
			end else if (chan_of(byte_addr) >= 0) begin
				readdata <= chan_read(byte_addr);
			end else begin
				readdata <= '0;
			end
		end
	end

	// Channel register read mux; the output bit shows the registered channel level pwm_level
	function automatic logic [DATA_W-1:0] chan_read(input logic [7:0] a);
		int c;
		logic [7:0] sub;
		c = chan_of(a);
		sub = a - OFS_CHAN_BASE - 8'(c) * CHAN_STRIDE;
		chan_read = '0;
		if (sub == OFS_CHAN_CONTROL) begin
			chan_read = DATA_W'({channel_enable[c], pin_drive_enable[c], pwm_level[c],
				output_invert[c], 4'h0});
		end else if (sub == OFS_CHAN_DUTY_HIGH) begin
			chan_read = DATA_W'(duty_high_bits[c]);
		end else if (sub == OFS_CHAN_DUTY_LOW) begin
			chan_read = DATA_W'({duty_low_bits[c], 6'h00});
		end
	endfunction

	// Timer control register
	always_ff @(posedge clock) begin
		if (srst) begin
			{postscale_select, timer_run, prescale_select} <= 7'(TIMER_CONTROL_RST);
		end else if (wr_control) begin
			prescale_select <= writedata[PRESCALE_LSB +: 2]; // [RULE_03]
			timer_run <= writedata[RUN_BIT]; // [RULE_09]
			postscale_select <= writedata[POSTSCALE_LSB +: 4]; // [RULE_05]
		end
	end

	// Period register; sleep does not touch it
	always_ff @(posedge clock) begin
		if (srst) begin
			period_value <= PERIOD_VALUE_RST; // [RULE_07]
		end else if (wr_period) begin
			period_value <= writedata[7:0]; // [RULE_07]
		end
	end

	// Prescale counter; cleared by count or control writes so a new setting starts clean
	always_ff @(posedge clock) begin
		if (srst || wr_count || wr_control) begin
			prescale_count <= 8'h00; // [RULE_08]
		end else if (running) begin
			prescale_count <= tick ? 8'h00 : prescale_count + 8'h01; // [RULE_01]
		end
	end

	// Timer count: software write wins over counting; a control write leaves it alone
	always_ff @(posedge clock) begin
		if (srst) begin
			timer_count <= TIMER_COUNT_RST; // [RULE_07]
		end else if (wr_count) begin
			timer_count <= writedata[7:0]; // [RULE_07]
		end else if (reload) begin
			timer_count <= 8'h00; // [RULE_04] [RULE_19]
		end else if (tick) begin
			timer_count <= timer_count + 8'h01; // [RULE_02]
		end
	end

	// Match pulse, one clock long, straight from a flop for downstream peripherals
	always_ff @(posedge clock) begin
		if (srst) begin
			period_match_pulse <= 1'b0;
		end else begin
			period_match_pulse <= reload && !wr_count; // [RULE_04] [RULE_10]
		end
	end

	// Postscaler counts matches and only drives the flag, never PWM timing
	always_ff @(posedge clock) begin
		if (srst || wr_count || wr_control) begin
			postscale_count <= 4'h0; // [RULE_08]
		end else if (period_match_pulse) begin
			postscale_count <= post_done ? 4'h0 : postscale_count + 4'h1; // [RULE_05] [RULE_21]
		end
	end

	// Match flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			match_irq_flag <= 1'b0;
			match_irq_enable <= 1'b0;
		end else begin
			if (period_match_pulse && post_done) begin
				match_irq_flag <= 1'b1; // [RULE_05] [RULE_06]
			end else if (wr_irq) begin
				match_irq_flag <= writedata[IRQ_FLAG_BIT];
			end
			if (wr_irq) begin
				match_irq_enable <= writedata[IRQ_ENABLE_BIT];
			end
		end
	end

	// Request only while the flag is held and enabled
	always_ff @(posedge clock) begin
		if (srst) begin
			match_irq_request <= 1'b0;
		end else begin
			match_irq_request <= match_irq_flag && match_irq_enable; // [RULE_06]
		end
	end

	// Per channel logic
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_chan
			localparam logic [7:0] BASE = OFS_CHAN_BASE + 8'(g) * CHAN_STRIDE;
			logic wr_ctl;
			logic wr_hi;
			logic wr_lo;
			logic raw_now;
			logic level;

			assign wr_ctl = do_write && byte_addr == BASE + OFS_CHAN_CONTROL;
			assign wr_hi = do_write && byte_addr == BASE + OFS_CHAN_DUTY_HIGH;
			assign wr_lo = do_write && byte_addr == BASE + OFS_CHAN_DUTY_LOW;
			// Raw level drops in the very cycle the time base meets the duty; the flop alone
			// would clear one clock late and stretch every pulse by one system clock
			assign raw_now = pwm_raw[g] && time_base != duty_active[g]; // [RULE_14]
			// Polarity one makes the channel active-low; a disabled channel rests low whatever the polarity
			assign level = channel_enable[g] && (raw_now ^ output_invert[g]); // [RULE_18] [RULE_23] [RULE_24]

			// Channel control and duty write buffers, writable at any time
			always_ff @(posedge clock) begin
				if (srst) begin
					channel_enable[g] <= 1'b0;
					pin_drive_enable[g] <= 1'b0;
					output_invert[g] <= 1'b0;
					duty_high_bits[g] <= DUTY_RST[9:2];
					duty_low_bits[g] <= DUTY_RST[1:0];
				end else begin
					if (wr_ctl) begin
						channel_enable[g] <= writedata[CH_ENABLE_BIT]; // [RULE_23]
						pin_drive_enable[g] <= writedata[CH_DRIVE_BIT]; // [RULE_22]
						output_invert[g] <= writedata[CH_INVERT_BIT]; // [RULE_24]
					end
					if (wr_hi) begin
						duty_high_bits[g] <= writedata[7:0]; // [RULE_14]
					end
					if (wr_lo) begin
						duty_low_bits[g] <= writedata[DUTY_LOW_LSB +: 2]; // [RULE_14]
					end
				end
			end

			// Active duty only moves at the period reload, so a half written pair waits
			always_ff @(posedge clock) begin
				if (srst) begin
					duty_active[g] <= DUTY_RST;
				end else if (reload) begin
					duty_active[g] <= {duty_high_bits[g], duty_low_bits[g]}; // [RULE_16] [RULE_17]
				end
			end

			// Raw waveform: set at reload unless duty is zero, cleared on time base match.
			// A duty past the last time base value never matches, giving full duty.
			always_ff @(posedge clock) begin
				if (srst) begin
					pwm_raw[g] <= 1'b0;
				end else if (!channel_enable[g]) begin
					pwm_raw[g] <= 1'b0; // [RULE_23]
				end else if (reload) begin
					pwm_raw[g] <= {duty_high_bits[g], duty_low_bits[g]} != 10'h000; // [RULE_13]
				end else if (!sleep && time_base == duty_active[g]) begin
					pwm_raw[g] <= 1'b0; // [RULE_14] [RULE_15] [RULE_12]
				end
			end

			// Pin and peripheral outputs frozen during sleep so the pin keeps its level
			always_ff @(posedge clock) begin
				if (srst) begin
					pwm_level[g] <= 1'b0;
					pwm_pin_out[g] <= 1'b0;
					pwm_pin_oe[g] <= 1'b0;
				end else if (!sleep) begin
					pwm_level[g] <= level;
					pwm_pin_out[g] <= pin_drive_enable[g] ? level : port_latch[g]; // [RULE_22]
					pwm_pin_oe[g] <= pin_drive_enable[g]; // [RULE_22] [RULE_12]
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ===== test/pwm_load.sv
// Load on the PWM pins: resolves each pad from driver and enable.
// Assumes one pin per channel with a pull-down on the pad.
`timescale 1ns/1ns
`default_nettype none
module pwm_load #(
	parameter int CHANNELS = 4
) (
	// Pin drivers
	input wire logic [CHANNELS-1:0] pin_out,
	input wire logic [CHANNELS-1:0] pin_oe,
	// Pad levels
	output logic [CHANNELS-1:0] pad
);
	// Released pad falls to the pull-down, never keeps the last value
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			pad[i] = pin_oe[i] ? pin_out[i] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== test/period_timer_pwm_chk.sv
// Port checker for the period timer and PWM block.
// Assumes one clock domain and registered outputs.
`timescale 1ns/1ns
`default_nettype none
module period_timer_pwm_chk #(
	parameter int CHANNELS = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bus
	input wire logic [period_timer_pwm_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [period_timer_pwm_pkg::DATA_W-1:0] writedata,
	input wire logic [period_timer_pwm_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	// Timer and PWM
	input wire logic sleep,
	input wire logic period_match_pulse,
	input wire logic match_irq_request,
	input wire logic [CHANNELS-1:0] pwm_level,
	input wire logic [CHANNELS-1:0] port_latch,
	input wire logic [CHANNELS-1:0] pwm_pin_out,
	input wire logic [CHANNELS-1:0] pwm_pin_oe
);
	import period_timer_pwm_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	// Outputs idle on the first edge after reset
	AST_RESET_IDLE: assert property ($fell(srst) |-> waitrequest && !period_match_pulse && pwm_pin_oe == '0)
		else $error("outputs not idle after reset");
	// Shortest period is four clocks
	AST_PULSE_SPACE: assert property (period_match_pulse |=> !period_match_pulse [*3])
		else $error("match pulses too close");
	// Sleep stops matches
	AST_SLEEP_NO_PULSE: assert property (sleep ##1 sleep |-> !period_match_pulse)
		else $error("match pulse during sleep");
	// Sleep freezes channel levels once the pipeline has settled
	AST_SLEEP_LEVEL: assert property (sleep [*3] |-> $stable(pwm_level))
		else $error("level moved during sleep");
	// Driven pin shows the same registered level as the peripheral output
	AST_PIN_DRIVE: assert property (!$past(srst) && pwm_pin_oe[0] |-> pwm_pin_out[0] == pwm_level[0])
		else $error("driven pin differs from level");
	// Released pin goes back to the port latch
	AST_PIN_RELEASE: assert property (!$past(srst) && !$past(sleep) && !pwm_pin_oe[0] |-> pwm_pin_out[0] == $past(port_latch[0]))
		else $error("released pin differs from latch");
	// Every request is answered within three cycles
	AST_BUS_ANSWER: assert property ((read || write) && waitrequest |-> ##[1:3] !waitrequest)
		else $error("bus request not answered");
	// Answer stands a single cycle
	AST_BUS_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");

	// Main scenarios
	COV_PULSE: cover property (period_match_pulse);
	COV_IRQ: cover property ($rose(match_irq_request));
	COV_SLEEP_PIN: cover property (sleep [*3] ##0 pwm_pin_oe[0]);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the period timer and PWM block.
// Assumes the register map and bus widths of the block's package.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import period_timer_pwm_pkg::*;
	logic clock, srst, read, write, sleep, waitrequest, period_match_pulse, match_irq_request;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata, readdata, q;
	logic [3:0] pwm_level, port_latch, pwm_pin_out, pwm_pin_oe, pad;
	int fail_count, tests_run;

	period_timer_pwm #(.CHANNELS(4)) u_dut (.clock(clock), .srst(srst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sleep(sleep), .period_match_pulse(period_match_pulse),
		.match_irq_request(match_irq_request), .pwm_level(pwm_level), .port_latch(port_latch),
		.pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe));
	pwm_load #(.CHANNELS(4)) u_load (.pin_out(pwm_pin_out), .pin_oe(pwm_pin_oe), .pad(pad));

	// 250 MHz clock
	always #2 clock = ~clock;

	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// One access; request held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h000000, d};
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			fail_count++;
			results();
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// Cycles up to the next match pulse, bounded
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (period_match_pulse !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			fail_count++;
			results();
		end
	endtask

	// High cycles of pad 0 over one 16-clock period, after the new duty is loaded
	task automatic high_cycles(output int h);
		int n;
		wait_pulse(n);
		wait_pulse(n);
		h = 0;
		repeat (16) begin
			@(posedge clock);
			if (pad[0] === 1'b1) h++;
		end
	endtask

	// Both duty halves go in before the control byte
	task automatic set_ch(input logic [9:0] d, input logic [7:0] ctl);
		xfer(1'b1, OFS_CHAN_BASE + OFS_CHAN_DUTY_HIGH, d[9:2]);
		xfer(1'b1, OFS_CHAN_BASE + OFS_CHAN_DUTY_LOW, {d[1:0], 6'h00});
		xfer(1'b1, OFS_CHAN_BASE + OFS_CHAN_CONTROL, ctl);
	endtask

	task automatic t_regs();
		xfer(1'b0, OFS_PERIOD_VALUE, 8'h00);
		chk("period reset", 32'h000000FF, q);
		xfer(1'b0, OFS_TIMER_COUNT, 8'h00);
		chk("count reset", 32'h0, q);
		xfer(1'b1, OFS_PERIOD_VALUE, 8'h5A);
		xfer(1'b0, OFS_PERIOD_VALUE, 8'h00);
		chk("period rw", 32'h5A, q);
		xfer(1'b0, 8'hFC, 8'h00);
		chk("unmapped", 32'h0, q);
	endtask

	// Stopped timer: a control write keeps the count
	task automatic t_count();
		xfer(1'b1, OFS_TIMER_COUNT, 8'h05);
		xfer(1'b1, OFS_TIMER_CONTROL, 8'h01);
		xfer(1'b0, OFS_TIMER_COUNT, 8'h00);
		chk("count kept", 32'h5, q);
		xfer(1'b0, OFS_TIMER_CONTROL, 8'h00);
		chk("control rw", 32'h1, q);
	endtask

	// Match spacing for every prescale code, period value 1
	task automatic t_prescale();
		int n;
		xfer(1'b1, OFS_PERIOD_VALUE, 8'h01);
		xfer(1'b1, OFS_TIMER_COUNT, 8'h00);
		for (int p = 0; p < 4; p++) begin
			xfer(1'b1, OFS_TIMER_CONTROL, 8'(p) | 8'h04);
			wait_pulse(n);
			wait_pulse(n);
			chk("period clocks", 32'(8 << (2 * p)), 32'(n));
		end
	endtask

	// Postscale 1:3 gates the flag, not the period
	task automatic t_post();
		int n, k;
		xfer(1'b1, OFS_TIMER_CONTROL, 8'h10);
		xfer(1'b1, OFS_PERIOD_VALUE, 8'h00);
		xfer(1'b1, OFS_MATCH_IRQ, 8'h02);
		xfer(1'b1, OFS_TIMER_CONTROL, 8'h14);
		n = 0;
		k = 0;
		while (match_irq_request !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
			if (period_match_pulse === 1'b1) k++;
		end
		if (n >= 200) begin
			fail_count++;
			results();
		end
		chk("matches per flag", 32'h3, 32'(k));
		wait_pulse(n);
		wait_pulse(n);
		chk("period with postscale", 32'h4, 32'(n));
		xfer(1'b1, OFS_MATCH_IRQ, 8'h00);
		repeat (4) wait_pulse(n);
		chk("masked request", 32'h0, 32'(match_irq_request));
		xfer(1'b0, OFS_MATCH_IRQ, 8'h00);
		chk("flag latched", 32'h1, q);
	endtask

	// Period 16 clocks at 1:1; duty, zero, full and inverted
	task automatic t_pwm();
		int h;
		xfer(1'b1, OFS_TIMER_CONTROL, 8'h04);
		xfer(1'b1, OFS_PERIOD_VALUE, 8'h03);
		set_ch(10'h006, 8'hC0);
		high_cycles(h);
		chk("duty six", 32'h6, 32'(h));
		set_ch(10'h000, 8'hC0);
		high_cycles(h);
		chk("duty zero", 32'h0, 32'(h));
		set_ch(10'h010, 8'hC0);
		high_cycles(h);
		chk("full duty", 32'h10, 32'(h));
		set_ch(10'h006, 8'hD0);
		high_cycles(h);
		chk("inverted", 32'hA, 32'(h));
	endtask

	// Released pin shows the latch; a disabled channel stays low
	task automatic t_release();
		int h;
		@(posedge clock);
		port_latch <= 4'hF;
		set_ch(10'h006, 8'h80);
		repeat (3) @(posedge clock);
		chk("released pin", 32'h1, 32'(pwm_pin_out[0]));
		chk("released oe", 32'h0, 32'(pwm_pin_oe[0]));
		set_ch(10'h006, 8'h40);
		high_cycles(h);
		chk("disabled channel", 32'h0, 32'(h));
		chk("disabled level", 32'h0, 32'(pwm_level[0]));
	endtask

	// Count holds in sleep and runs again after
	task automatic t_sleep();
		int n;
		logic [31:0] held;
		logic held_pad;
		set_ch(10'h006, 8'hC0);
		@(posedge clock);
		sleep <= 1'b1;
		repeat (3) @(posedge clock);
		xfer(1'b0, OFS_TIMER_COUNT, 8'h00);
		held = q;
		held_pad = pad[0];
		repeat (20) @(posedge clock);
		xfer(1'b0, OFS_TIMER_COUNT, 8'h00);
		chk("count in sleep", held, q);
		chk("pin in sleep", 32'(held_pad), 32'(pad[0]));
		chk("pin driven in sleep", 32'h1, 32'(pwm_pin_oe[0]));
		@(posedge clock);
		sleep <= 1'b0;
		wait_pulse(n);
		wait_pulse(n);
		chk("resumed period", 32'h10, 32'(n));
	endtask

	initial begin
		clock = 1'b0;
		srst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		sleep = 1'b0;
		address = '0;
		writedata = '0;
		port_latch = '0;
		fail_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		t_regs();
		t_count();
		t_prescale();
		t_post();
		t_pwm();
		t_release();
		t_sleep();
		results();
	end
endmodule

bind period_timer_pwm period_timer_pwm_chk #(.CHANNELS(CHANNELS)) u_chk (.clock(clock),
	.srst(srst), .address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .sleep(sleep),
	.period_match_pulse(period_match_pulse), .match_irq_request(match_irq_request),
	.pwm_level(pwm_level), .port_latch(port_latch), .pwm_pin_out(pwm_pin_out),
	.pwm_pin_oe(pwm_pin_oe));
`default_nettype wire
